// *** logic/wake_common_regs.sv ***
/*
 * Common wake-up register set with standby data-in/data-out registers,
 * sticky event status, interrupt gating and a banked window.
 * Assumes an APB master on mclk; pins arrive asynchronously.
 */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module wake_common_regs (
    input  wire logic                                 mclk,
    input  wire logic                                 reset,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [wake_common_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [7:0]                           wakeEventA,
    input  wire logic                                 softwareReset,
    input  wire logic [1:0]                           standbyEventInput,
    input  wire logic [wake_common_pkg::DOUT_A_W-1:0] standbyEventIoPinIn,
    output logic      [wake_common_pkg::DOUT_A_W-1:0] standbyEventIoPinOut,
    output logic      [wake_common_pkg::DOUT_A_W-1:0] standbyEventIoPinOe,
    input  wire logic [wake_common_pkg::DOUT_B_W-1:0] standbyOutputPinIn,
    output logic      [wake_common_pkg::DOUT_B_W-1:0] standbyOutputPinOut,
    output logic      [wake_common_pkg::DOUT_B_W-1:0] standbyOutputPinOe,
    input  wire logic [1:0]                           standbyInputPin,
    output logic                                      powerButtonPulseS3,
    output logic                                      swapKeyboardInputs,
    output logic      [1:0]                           bankSelect,
    output logic                                      wakeIrq
);
    import wake_common_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [SYNC_W-1:0] pinLevel;
    logic [7:0]        eventLevel;
    logic [7:0]        eventLevelPrev;
    logic [DIN_B_W-1:0] dataInB;
    logic [7:0]        eventRise;

    pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   ({standbyInputPin, standbyOutputPinIn, standbyEventInput, standbyEventIoPinIn}),
        .dout  (pinLevel)
    );

    assign eventLevel = pinLevel[7:0];
    assign dataInB    = pinLevel[11:8];
    assign eventRise  = eventLevel & ~eventLevelPrev;

    // Starts low: a pin high at reset counts as one rise
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            eventLevelPrev <= 8'h00;
        end else begin
            eventLevelPrev <= eventLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [IDX_W-1:0] idx;
    logic setupPhase;
    logic accessPhase;
    logic writeStrobe;
    logic isCommon;
    logic isBank;
    logic isOwn;
    logic mapped;
    logic [IDX_W-1:0] bankOffset;
    logic [IDX_W-1:0] bankAddr;

    assign idx         = paddr[ADDR_W-1:2];
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign isCommon    = idx <= IDX_COMMON_LAST;
    assign isBank      = idx >= IDX_BANK_FIRST && idx <= IDX_BANK_LAST;
    assign isOwn       = idx >= IDX_CLEAR_A && idx <= IDX_IO_OE;
    assign mapped      = isCommon || isBank || isOwn;
    assign writeStrobe = accessPhase && pwrite && mapped;
    assign pready      = 1'b1;
    // Reserved common holes answer without error
    assign pslverr     = accessPhase && !mapped;
    assign bankOffset  = idx - IDX_BANK_FIRST;
    assign bankAddr    = IDX_W'(bankSelect * BANK_REGS) + bankOffset;

    logic wrStatusClrA;
    logic wrStatusClrB;
    logic wrEnableA;
    logic wrEnableB;
    logic wrWakeCfg;
    logic wrDoutA;
    logic wrDoutB;
    logic wrPinCfg;
    logic wrIoOe;
    logic wrBank;

    assign wrStatusClrA = writeStrobe && idx == IDX_CLEAR_A;
    assign wrStatusClrB = writeStrobe && idx == IDX_CLEAR_B;
    assign wrEnableA    = writeStrobe && idx == IDX_ENABLE_A;
    assign wrEnableB    = writeStrobe && idx == IDX_ENABLE_B;
    assign wrWakeCfg    = writeStrobe && idx == IDX_WAKE_CFG;
    assign wrDoutA      = writeStrobe && idx == IDX_DOUT_A;
    assign wrDoutB      = writeStrobe && idx == IDX_DOUT_B;
    assign wrPinCfg     = writeStrobe && idx == IDX_PIN_CFG;
    assign wrIoOe       = writeStrobe && idx == IDX_IO_OE;
    assign wrBank       = writeStrobe && isBank && bankSelect != BANK_NONE;

    ////////////////////////////////////////////////////////////////////////
    // Status, enable and interrupt
    logic [7:0] statusA;
    logic [7:0] statusB;
    logic [7:0] enableA;
    logic [7:0] enableB;
    logic [7:0] setA;
    logic [7:0] clrA;
    logic [7:0] clrB;

    assign setA = wakeEventA | (8'(|(eventRise & enableB)) << STS_A_GPIO_BIT);
    assign clrA = wrStatusClrA ? pwdata[7:0] : 8'h00;
    assign clrB = wrStatusClrB ? pwdata[7:0] : 8'h00;

    // Set wins over a same-cycle clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            statusA <= 8'h00;
            statusB <= 8'h00;
        end else begin
            statusA <= (statusA & ~clrA) | setA;
            statusB <= (statusB & ~clrB) | eventRise;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            enableA <= 8'h00;
            enableB <= 8'h00;
        end else begin
            if (wrEnableA) begin
                enableA <= pwdata[7:0];
            end
            if (wrEnableB) begin
                enableB <= pwdata[7:0];
            end
        end
    end

    assign wakeIrq = |(statusA & enableA) || |(statusB & enableB);

    ////////////////////////////////////////////////////////////////////////
    // Wake configuration
    logic [CFG_W-1:0] wakeCfg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wakeCfg <= '0;
        end else if (wrWakeCfg) begin
            wakeCfg <= pwdata[CFG_W-1:0];
        end
    end

    assign bankSelect         = wakeCfg[CFG_BANK_LO +: 2];
    assign swapKeyboardInputs = wakeCfg[CFG_SWAP_BIT];
    assign powerButtonPulseS3 = wakeCfg[CFG_PULSE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Standby data-out and pin configuration
    logic [DOUT_A_W-1:0] dataOutA;
    logic [DOUT_A_W-1:0] ioOe;
    logic [DOUT_B_W-1:0] dataOutB;
    logic [DOUT_B_W-1:0] outOe;
    logic [DOUT_B_W-1:0] outLock;
    logic [DOUT_B_W-1:0] next_dataOutB;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dataOutA <= '0;
            ioOe     <= '0;
        end else begin
            if (wrDoutA) begin
                dataOutA <= pwdata[DOUT_A_W-1:0];
            end
            if (wrIoOe) begin
                ioOe <= pwdata[DOUT_A_W-1:0];
            end
        end
    end

    // Lock bits stay set until hardware reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            outOe   <= '0;
            outLock <= '0;
        end else if (wrPinCfg) begin
            outOe   <= pwdata[PCFG_OE_LO +: DOUT_B_W];
            outLock <= outLock | pwdata[PCFG_LOCK_LO +: DOUT_B_W];
        end
    end

    // Lock outranks software reset, which outranks a write
    generate
        for (genvar b = 0; b < DOUT_B_W; b++) begin : g_dout_b
            always_comb begin
                next_dataOutB[b] = dataOutB[b];
                if (outLock[b]) begin
                    next_dataOutB[b] = dataOutB[b];
                end else if (softwareReset) begin
                    next_dataOutB[b] = DOUT_B_RESET[b];
                end else if (wrDoutB) begin
                    next_dataOutB[b] = pwdata[b];
                end
            end
        end
    endgenerate

    // Hardware reset reloads whatever the lock held
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dataOutB <= DOUT_B_RESET;
        end else begin
            dataOutB <= next_dataOutB;
        end
    end

    assign standbyOutputPinOut  = dataOutB;
    assign standbyOutputPinOe   = outOe;
    assign standbyEventIoPinOut = dataOutA;
    assign standbyEventIoPinOe  = ioOe;

    ////////////////////////////////////////////////////////////////////////
    // Banked window storage
    // Window writes with no bank selected are dropped
    logic [7:0] bankMem [0:BANK_WORDS-1];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < BANK_WORDS; i++) begin
                bankMem[i] <= 8'h00;
            end
        end else if (wrBank) begin
            bankMem[bankAddr] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data
    logic [7:0] readValue;
    logic [7:0] bankRead;

    assign bankRead = (bankSelect == BANK_NONE) ? 8'h00 : bankMem[bankAddr];

    always_comb begin
        readValue = 8'h00;
        unique case (idx)
            IDX_STATUS_A: readValue = statusA;
            IDX_STATUS_B: readValue = statusB;
            IDX_ENABLE_A: readValue = enableA;
            IDX_ENABLE_B: readValue = enableB;
            IDX_WAKE_CFG: readValue = 8'(wakeCfg);
            IDX_DOUT_A:   readValue = 8'(dataOutA);
            IDX_DIN_A:    readValue = eventLevel;
            IDX_DOUT_B:   readValue = 8'(dataOutB);
            IDX_DIN_B:    readValue = 8'(dataInB);
            IDX_PIN_CFG:  readValue = 8'({outLock, outOe});
            IDX_IO_OE:    readValue = 8'(ioOe);
            default:      readValue = isBank ? bankRead : 8'h00;
        endcase
    end

    // Latched in setup, stands through access
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata <= {24'h00_0000, readValue};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic rdSetup;
    logic wrSetup;
    assign rdSetup = setupPhase && !pwrite;
    assign wrSetup = setupPhase && pwrite;

    AST_DIN_A_LIVE: assert property (rdSetup && idx == IDX_DIN_A |=> prdata == {24'h0, $past(eventLevel)})
        else $error("data-in A read does not match pin level");
    AST_DIN_A_PIN: assert property (!$past(reset) && !$past(reset, 2)
            |-> eventLevel == $past({standbyEventInput, standbyEventIoPinIn}, 2))
        else $error("data-in bits do not follow pins");
    AST_SWRST_LOAD: assert property (softwareReset
            |=> (~dataOutB & DOUT_B_RESET & ~$past(outLock)) == 2'h0)
        else $error("software reset did not load data-out B");
    AST_PIN_DRIVE: assert property (wrDoutB && !softwareReset && outLock == 2'h0
            |=> standbyOutputPinOut == $past(pwdata[1:0]))
        else $error("standby output pins do not follow written data");
    AST_LOCK_HOLD: assert property (outLock != 2'h0
            |=> ((dataOutB ^ $past(dataOutB)) & $past(outLock)) == 2'h0)
        else $error("locked data-out bit changed");
    AST_DOUT_READBACK: assert property (rdSetup && idx == IDX_DOUT_B
            |=> prdata[7:0] == {6'h00, $past(dataOutB)})
        else $error("data-out B readback wrong");
    AST_DIN_B_RSVD: assert property (rdSetup && idx == IDX_DIN_B
            |=> prdata[7:4] == 4'h0 && prdata[3:0] == $past(dataInB))
        else $error("data-in B read wrong");
    AST_COMMON_MAPPED: assert property (accessPhase && idx <= IDX_COMMON_LAST |-> !pslverr)
        else $error("common register answered with error");
    AST_CFG_WRITE: assert property (wrWakeCfg |=> bankSelect == $past(pwdata[1:0])
            && swapKeyboardInputs == $past(pwdata[2]))
        else $error("wake configuration not written");
    AST_STICKY_B: assert property (eventRise[7] || statusB[7] && !clrB[7]
            |=> statusB[7])
        else $error("status B bit not sticky after event");
    AST_RSVD_HOLE: assert property (rdSetup && idx inside {[6'h05:6'h07], [6'h0C:IDX_COMMON_LAST]}
            |=> prdata == 32'h0)
        else $error("reserved offset reads nonzero");
    AST_IO_OE_WRITE: assert property (wrIoOe |=> standbyEventIoPinOe == $past(pwdata[DOUT_A_W-1:0]))
        else $error("I/O pin output enables not written");
    AST_BANK_EMPTY: assert property (rdSetup && isBank && bankSelect == BANK_NONE |=> prdata == 32'h0)
        else $error("unbanked window reads nonzero");

    COV_IRQ_RISE:    cover property ($rose(wakeIrq));
    COV_LOCKED_WR:   cover property (wrDoutB && outLock != 2'h0);
    COV_BANK1_WRITE: cover property (wrBank && bankSelect == 2'h1);
    COV_UNMAPPED:    cover property (pslverr);
    COV_SWRST_LOAD:  cover property (softwareReset && outLock != 2'h3);

endmodule : wake_common_regs

// *** logic/wake_common_pkg.sv ***
/*
 * Constants for the wake-up common register set: register indices,
 * field positions, reset values and widths.
 * Assumes a 32-bit APB slave where byte address = 4 * index.
 */
package wake_common_pkg;
    localparam int ADDR_W = 8;
    localparam int IDX_W  = 6;
    localparam logic [IDX_W-1:0] IDX_STATUS_A = 6'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS_B = 6'h01;
    localparam logic [IDX_W-1:0] IDX_ENABLE_A = 6'h02;
    localparam logic [IDX_W-1:0] IDX_ENABLE_B = 6'h03;
    localparam logic [IDX_W-1:0] IDX_WAKE_CFG = 6'h04;
    localparam logic [IDX_W-1:0] IDX_DOUT_A   = 6'h08;
    localparam logic [IDX_W-1:0] IDX_DIN_A    = 6'h09;
    localparam logic [IDX_W-1:0] IDX_DOUT_B   = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_DIN_B    = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_COMMON_LAST = 6'h12;
    localparam logic [IDX_W-1:0] IDX_BANK_FIRST  = 6'h13;
    localparam logic [IDX_W-1:0] IDX_BANK_LAST   = 6'h1F;
    localparam logic [IDX_W-1:0] IDX_CLEAR_A  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_CLEAR_B  = 6'h21;
    localparam logic [IDX_W-1:0] IDX_PIN_CFG  = 6'h22;
    localparam logic [IDX_W-1:0] IDX_IO_OE    = 6'h23;
    localparam int BANK_REGS  = 13;
    localparam int BANK_COUNT = 3;
    localparam int BANK_WORDS = BANK_REGS * BANK_COUNT;
    localparam logic [1:0] BANK_NONE = 2'h3;
    localparam int CFG_W         = 4;
    localparam int CFG_BANK_LO   = 0;
    localparam int CFG_SWAP_BIT  = 2;
    localparam int CFG_PULSE_BIT = 3;
    localparam int DOUT_A_W = 6;
    localparam int DOUT_B_W = 2;
    localparam int DIN_B_W  = 4;
    localparam int PCFG_OE_LO   = 0;
    localparam int PCFG_LOCK_LO = 2;
    localparam int STS_A_GPIO_BIT = 5;
    localparam logic [DOUT_B_W-1:0] DOUT_B_RESET = 2'h3;
    localparam int SYNC_W = 12;
endpackage : wake_common_pkg

// *** logic/pin_sync.sv ***
/*
 * Two-stage synchroniser for a bus of independent pin levels.
 * Assumes each bit is a slow level; no bus coherence is given.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : pin_sync

// *** tb/wake_common_regs_tb.sv ***
/*
 * Self-checking bench for the wake-up common register set.
 * Assumes zero-wait APB, byte address = 4 * index, two-edge pin sync.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failCount++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module wake_common_regs_tb;
    import wake_common_pkg::*;
    logic        mclk, reset, psel, penable, pwrite, pready, pslverr, softwareReset;
    logic [7:0]  paddr, wakeEventA;
    logic [31:0] pwdata, prdata, rdData;
    logic        rdErr, powerButtonPulseS3, swapKeyboardInputs, wakeIrq;
    logic [1:0]  standbyEventInput, standbyOutputPinIn, standbyOutputPinOut, standbyOutputPinOe;
    logic [1:0]  standbyInputPin, bankSelect;
    logic [5:0]  standbyEventIoPinIn, standbyEventIoPinOut, standbyEventIoPinOe;
    int          failCount, comparisons;

    wake_common_regs i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wakeEventA(wakeEventA), .softwareReset(softwareReset), .standbyEventInput(standbyEventInput),
        .standbyEventIoPinIn(standbyEventIoPinIn), .standbyEventIoPinOut(standbyEventIoPinOut),
        .standbyEventIoPinOe(standbyEventIoPinOe), .standbyOutputPinIn(standbyOutputPinIn),
        .standbyOutputPinOut(standbyOutputPinOut), .standbyOutputPinOe(standbyOutputPinOe),
        .standbyInputPin(standbyInputPin), .powerButtonPulseS3(powerButtonPulseS3),
        .swapKeyboardInputs(swapKeyboardInputs), .bankSelect(bankSelect), .wakeIrq(wakeIrq));

    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr  = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        `CHK(rdData, {24'h0, exp})
    endtask : rd_chk

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : wait_clk

    ////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        rd_chk(IDX_DOUT_B, 8'h03);
        `CHK(standbyOutputPinOut, 2'h3)
        rd_chk(IDX_WAKE_CFG, 8'h00);
        `CHK(wakeIrq, 1'b0)
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_data_in;
        apb(1'b1, IDX_DOUT_A, 8'h3C);
        standbyEventInput <= 2'h2; standbyEventIoPinIn <= 6'h05;
        standbyOutputPinIn <= 2'h1; standbyInputPin <= 2'h2;
        wait_clk(4);
        `CHK(standbyEventIoPinOut, 6'h3C)
        apb(1'b1, IDX_IO_OE, 8'h2A);
        wait_clk(1);
        `CHK(standbyEventIoPinOe, 6'h2A)
        rd_chk(IDX_IO_OE, 8'h2A);
        rd_chk(IDX_DIN_A, 8'h85);
        apb(1'b1, IDX_DIN_A, 8'hFF);
        rd_chk(IDX_DIN_A, 8'h85);
        rd_chk(IDX_DIN_B, 8'h09);
        apb(1'b1, IDX_DIN_B, 8'hFF);
        rd_chk(IDX_DIN_B, 8'h09);
        $display("test data_in done");
    endtask : test_data_in

    task automatic test_data_out_lock;
        apb(1'b1, IDX_PIN_CFG, 8'h03);
        apb(1'b1, IDX_DOUT_B, 8'hFE);
        wait_clk(1);
        `CHK(standbyOutputPinOe, 2'h3)
        `CHK(standbyOutputPinOut, 2'h2)
        rd_chk(IDX_DOUT_B, 8'h02);
        apb(1'b1, IDX_PIN_CFG, 8'h07);
        apb(1'b1, IDX_DOUT_B, 8'h01);
        rd_chk(IDX_DOUT_B, 8'h00);
        @(posedge mclk);
        softwareReset <= 1'b1;
        @(posedge mclk);
        softwareReset <= 1'b0;
        rd_chk(IDX_DOUT_B, 8'h02);
        $display("test data_out_lock done");
    endtask : test_data_out_lock

    task automatic test_config_banks;
        apb(1'b1, IDX_WAKE_CFG, 8'hFF);
        wait_clk(1);
        `CHK({powerButtonPulseS3, swapKeyboardInputs, bankSelect}, 4'hF)
        rd_chk(IDX_WAKE_CFG, 8'h0F);
        rd_chk(IDX_BANK_FIRST, 8'h00);
        `CHK(rdErr, 1'b0)
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, IDX_WAKE_CFG, 8'(b));
            apb(1'b1, IDX_ENABLE_B, 8'(8'h11 << b));
            apb(1'b1, IDX_BANK_FIRST, 8'(8'hA0 + b));
        end
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, IDX_WAKE_CFG, 8'(b));
            rd_chk(IDX_ENABLE_B, 8'h22);
            rd_chk(IDX_BANK_FIRST, 8'(8'hA0 + b));
        end
        apb(1'b1, IDX_ENABLE_B, 8'h00);
        $display("test config_banks done");
    endtask : test_config_banks

    task automatic test_events;
        standbyEventInput <= 2'h0;
        wait_clk(4);
        apb(1'b1, IDX_CLEAR_A, 8'hFF);
        apb(1'b1, IDX_CLEAR_B, 8'hFF);
        rd_chk(IDX_STATUS_B, 8'h00);
        apb(1'b1, IDX_ENABLE_A, 8'h40);
        @(posedge mclk);
        wakeEventA <= 8'h40;
        @(posedge mclk);
        wakeEventA <= 8'h00;
        wait_clk(1);
        `CHK(wakeIrq, 1'b1)
        apb(1'b1, IDX_STATUS_A, 8'h00);
        rd_chk(IDX_STATUS_A, 8'h40);
        apb(1'b1, IDX_ENABLE_A, 8'h00);
        wait_clk(1);
        `CHK(wakeIrq, 1'b0)
        apb(1'b1, IDX_CLEAR_A, 8'h40);
        rd_chk(IDX_STATUS_A, 8'h00);
        apb(1'b1, IDX_ENABLE_B, 8'h80);
        standbyEventInput <= 2'h2;
        wait_clk(6);
        `CHK(wakeIrq, 1'b1)
        rd_chk(IDX_STATUS_B, 8'h80);
        rd_chk(IDX_STATUS_A, 8'h20);
        apb(1'b1, IDX_CLEAR_B, 8'h80);
        apb(1'b1, IDX_CLEAR_A, 8'h20);
        wait_clk(1);
        `CHK(wakeIrq, 1'b0)
        $display("test events done");
    endtask : test_events

    task automatic test_reserved;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, i < 2 ? 6'(6'h05 + 2 * i) : 6'(6'h0C + 6 * (i - 2)), 8'hFF);
            `CHK(rdErr, 1'b0)
            rd_chk(i < 2 ? 6'(6'h05 + 2 * i) : 6'(6'h0C + 6 * (i - 2)), 8'h00);
            `CHK(rdErr, 1'b0)
        end
        $display("test reserved done");
    endtask : test_reserved

    task automatic test_hw_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(IDX_DOUT_B, 8'h03);
        $display("test hw_reset done");
    endtask : test_hw_reset

    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        wakeEventA = 8'h00; softwareReset = 1'b0; standbyEventInput = 2'h0; standbyEventIoPinIn = 6'h00;
        standbyOutputPinIn = 2'h0; standbyInputPin = 2'h0;
        failCount = 0; comparisons = 0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        test_reset_values();
        test_data_in();
        test_data_out_lock();
        test_config_banks();
        test_events();
        test_reserved();
        test_hw_reset();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        complete_run();
    end
endmodule : wake_common_regs_tb
